// ==== fsrc_pkg.sv ====
// Package for the range and calibration control register bank.
// Assumes a 16-bit serial register port with 4-bit addresses.
package fsrc_pkg;
  localparam logic [3:0]  ADDR_FSR       = 4'h3;
  localparam logic [3:0]  ADDR_CAL_ADJ   = 4'h4;
  localparam logic [3:0]  ADDR_CAL_VAL   = 4'h5;
  localparam logic [15:0] FSR_RESET      = 16'h4000;
  localparam logic [15:0] CAL_ADJ_RESET  = 16'hDB4B;
  localparam logic [15:0] CAL_ADJ_RSVD   = 16'hBF7F;
  localparam logic [14:0] MAG_MID        = 15'h4000;
  localparam logic [14:0] MAG_MAX        = 15'h7FFF;
  localparam logic [14:0] MAG_LOW        = 15'h0000;
  localparam int          SEQ_BIT        = 14;
  localparam int          SCAN_BIT       = 7;
  localparam int          MONO_BITS      = 9;
  localparam int          FSR_MIN_MV     = 600;
  localparam int          FSR_MAX_MV     = 1000;
  localparam logic [3:0]  STEP_CYCLES    = 4'h4;
  typedef enum logic [2:0] {
    CAL_IDLE  = 3'b000,
    CAL_RESET = 3'b001,
    CAL_TERM  = 3'b010,
    CAL_LIN   = 3'b011,
    CAL_STORE = 3'b100
  } fsrc_cal_state_t;
endpackage : fsrc_pkg

// ==== fsrc_cal_if.sv ====
// Carrier between the register bank and the calibration value store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface fsrc_cal_if;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport bank  (output wr_en, output wr_data, input rd_data);
  modport store (input wr_en, input wr_data, output rd_data);
endinterface : fsrc_cal_if
`default_nettype wire

// ==== fsrc_cal_store.sv ====
// Calibration value word, registered read data.
// Assumes writes arrive already qualified by the bank.
`timescale 1ns/1ns
`default_nettype none
module fsrc_cal_store (
  input  wire logic sys_clk,
  input  wire logic rst,
  fsrc_cal_if.store cal
);
  logic [15:0] word_q;
  // Power-on content undefined in silicon; zero here for determinism
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_q <= 16'h0000;
    end else if (cal.wr_en) begin
      word_q <= cal.wr_data;
    end
  end
  assign cal.rd_data = word_q;
endmodule : fsrc_cal_store
`default_nettype wire

// ==== fsrc_regs.sv ====
// Range magnitude and calibration control register bank.
// Assumes the serial protocol engine presents decoded one-cycle
// read and write strobes with a 4-bit address, synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Range magnitude is straight binary, code 0 smallest, 32767 largest.
// - Range magnitude resets to 16384, the nominal midpoint.
// - Only the upper 9 magnitude bits are monotonic by design.
// - Extended mode midpoint and low codes match pin-control nominal and low.
// - Ranges above midpoint only reachable in extended control mode.
// - Sequence bit one: reset elements, calibrate termination, then linearity.
// - Sequence bit zero: keep termination, run only linearity calibration.
// - Scan-access bit one opens calibration values at address 5h.
// - Address 5h holds calibration results, accessible only with scan set.
module fsrc_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        extended_control_mode,
  input  wire logic        pin_range_low,
  input  wire logic        cal_start,
  input  wire logic [15:0] cal_result,
  output logic      [14:0] range_magnitude,
  output logic             cal_busy,
  output logic             term_reset,
  output logic             term_cal,
  output logic             lin_cal,
  output logic             term_calibrated
);
  logic [15:0]                fsr_q;
  logic [15:0]                adj_q;
  logic [15:0]                rdata_q;
  logic                       termok_q;
  logic [3:0]                 step_q;
  fsrc_pkg::fsrc_cal_state_t  st_q;
  logic                       cal_sequence_select;
  logic                       cal_scan_access;
  logic                       scan_wr;
  logic                       step_done;
  fsrc_cal_if                 cal ();

  fsrc_cal_store u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cal     (cal)
  );

  assign cal_sequence_select = adj_q[fsrc_pkg::SEQ_BIT];
  assign cal_scan_access     = adj_q[fsrc_pkg::SCAN_BIT];

  // Bit 15 stored as written; host keeps it zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fsr_q <= fsrc_pkg::FSR_RESET;
    end else if (reg_wr && reg_addr == fsrc_pkg::ADDR_FSR) begin
      fsr_q <= reg_wdata;
    end
  end

  // Reserved bits held as written; host restores defaults
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adj_q <= fsrc_pkg::CAL_ADJ_RESET;
    end else if (reg_wr && reg_addr == fsrc_pkg::ADDR_CAL_ADJ) begin
      adj_q <= reg_wdata;
    end
  end

  // Pin control caps at midpoint; codes pass straight binary
  // All 15 bits applied; only the top 9 guarantee monotonic steps
  always_comb begin
    if (extended_control_mode) begin
      range_magnitude = fsr_q[14:0];
    end else if (pin_range_low) begin
      range_magnitude = fsrc_pkg::MAG_LOW;
    end else begin
      range_magnitude = fsrc_pkg::MAG_MID;
    end
  end

  // Scan window: host write lands only with scan bit set
  assign scan_wr = reg_wr && reg_addr == fsrc_pkg::ADDR_CAL_VAL && cal_scan_access;
  assign cal.wr_en   = scan_wr || st_q == fsrc_pkg::CAL_STORE;
  // Calibration result beats a same-cycle scan write; the engine owns the word
  assign cal.wr_data = (st_q == fsrc_pkg::CAL_STORE) ? cal_result : reg_wdata;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fsrc_pkg::ADDR_FSR:     rdata_q <= fsr_q;
        fsrc_pkg::ADDR_CAL_ADJ: rdata_q <= adj_q;
        fsrc_pkg::ADDR_CAL_VAL: rdata_q <= cal_scan_access ? cal.rd_data : 16'h0000;
        default:                rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // Each calibration phase lasts a fixed step count
  assign step_done = step_q == fsrc_pkg::STEP_CYCLES - 4'h1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_q <= 4'h0;
    end else if (st_q == fsrc_pkg::CAL_IDLE || step_done) begin
      step_q <= 4'h0;
    end else begin
      step_q <= step_q + 4'h1;
    end
  end

  // Sequence picked at start; later runs may take either path
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= fsrc_pkg::CAL_IDLE;
    end else begin
      unique case (st_q)
        fsrc_pkg::CAL_IDLE: begin
          if (cal_start) begin
            st_q <= cal_sequence_select ? fsrc_pkg::CAL_RESET : fsrc_pkg::CAL_LIN;
          end
        end
        fsrc_pkg::CAL_RESET: if (step_done) st_q <= fsrc_pkg::CAL_TERM;
        fsrc_pkg::CAL_TERM:  if (step_done) st_q <= fsrc_pkg::CAL_LIN;
        fsrc_pkg::CAL_LIN:   if (step_done) st_q <= fsrc_pkg::CAL_STORE;
        fsrc_pkg::CAL_STORE: st_q <= fsrc_pkg::CAL_IDLE;
        default:             st_q <= fsrc_pkg::CAL_IDLE;
      endcase
    end
  end

  // Tracks whether a full run has calibrated termination
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      termok_q <= 1'b0;
    end else if (st_q == fsrc_pkg::CAL_TERM && step_done) begin
      termok_q <= 1'b1;
    end
  end

  assign cal_busy        = st_q != fsrc_pkg::CAL_IDLE;
  assign term_reset      = st_q == fsrc_pkg::CAL_RESET;
  assign term_cal        = st_q == fsrc_pkg::CAL_TERM;
  assign lin_cal         = st_q == fsrc_pkg::CAL_LIN;
  assign term_calibrated = termok_q;

  sequence s_full_path;
    term_reset [*4] ##1 term_cal [*4] ##1 lin_cal [*4];
  endsequence
  sequence s_short_path;
    (lin_cal && !term_reset && !term_cal) [*4] ##1 !term_cal;
  endsequence
  // Host leaves one idle cycle between a write and the next read
  sequence s_scan_write;
    (scan_wr && !cal_busy) ##1 !cal.wr_en;
  endsequence

  chk_full_cal_order: assert property (@(posedge sys_clk) disable iff (rst)
    (!cal_busy && cal_start && cal_sequence_select) |=> s_full_path)
    else $error("Full calibration did not run reset, termination, linearity");
  chk_short_cal_path: assert property (@(posedge sys_clk) disable iff (rst)
    (!cal_busy && cal_start && !cal_sequence_select) |=> s_short_path)
    else $error("Short calibration touched termination");
  chk_range_pin_cap: assert property (@(posedge sys_clk) disable iff (rst)
    !extended_control_mode |-> range_magnitude <= fsrc_pkg::MAG_MID)
    else $error("Range above midpoint under pin control");
  chk_range_ext_pass: assert property (@(posedge sys_clk) disable iff (rst)
    extended_control_mode |-> range_magnitude == fsr_q[14:0])
    else $error("Extended mode range not taken from register");
  chk_range_pin_low: assert property (@(posedge sys_clk) disable iff (rst)
    (!extended_control_mode && pin_range_low) |-> range_magnitude == fsrc_pkg::MAG_LOW)
    else $error("Pin low setting does not match low code");
  chk_scan_blocked: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == fsrc_pkg::ADDR_CAL_VAL && !cal_scan_access)
      |=> reg_rdata == 16'h0000)
    else $error("Calibration values readable with scan closed");
  chk_scan_roundtrip: assert property (@(posedge sys_clk) disable iff (rst)
    s_scan_write ##1 (reg_rd && reg_addr == fsrc_pkg::ADDR_CAL_VAL
      && cal_scan_access && !cal.wr_en) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Scan write not read back");
  chk_fsr_reset_mid: assert property (@(posedge sys_clk)
    $fell(rst) |-> fsr_q[14:0] == fsrc_pkg::MAG_MID)
    else $error("Range magnitude not at midpoint after reset");
  chk_term_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(term_cal) |-> term_calibrated)
    else $error("Termination flag not set after termination step");
  chk_fsr_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == fsrc_pkg::ADDR_FSR) |=> fsr_q == $past(reg_wdata))
    else $error("Range register write did not land");
  chk_fsr_read_back: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == fsrc_pkg::ADDR_FSR) |=> reg_rdata == $past(fsr_q))
    else $error("Range register read returned wrong word");
  chk_adj_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == fsrc_pkg::ADDR_CAL_ADJ) |=> adj_q == $past(reg_wdata))
    else $error("Calibration adjust write did not land");
  chk_adj_read_back: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == fsrc_pkg::ADDR_CAL_ADJ) |=> reg_rdata == $past(adj_q))
    else $error("Calibration adjust read returned wrong word");
  // A closed window must leave the stored word untouched
  chk_scan_wr_blocked: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == fsrc_pkg::ADDR_CAL_VAL && !cal_scan_access
      && st_q != fsrc_pkg::CAL_STORE) |=> $stable(cal.rd_data))
    else $error("Calibration word changed by write with scan closed");
  chk_store_result: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == fsrc_pkg::CAL_STORE) |=> cal.rd_data == $past(cal_result))
    else $error("Calibration result not stored at end of run");
  chk_pin_nominal: assert property (@(posedge sys_clk) disable iff (rst)
    (!extended_control_mode && !pin_range_low) |-> range_magnitude == fsrc_pkg::MAG_MID)
    else $error("Pin nominal setting does not match midpoint code");
  // A start while busy must not cut the run short
  chk_start_while_busy: assert property (@(posedge sys_clk) disable iff (rst)
    (cal_busy && cal_start && st_q != fsrc_pkg::CAL_STORE) |=> cal_busy)
    else $error("Start during calibration ended the run");
endmodule : fsrc_regs
`default_nettype wire

// ==== fsrc_host_model.sv ====
// Host model: drives register strobes and samples read data.
// Assumes sys_clk is shared with the register bank.
`timescale 1ns/1ns
`default_nettype none
module fsrc_host_model (
  input  wire logic        sys_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'hF;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] w;
    w = d;
    if (a == fsrc_pkg::ADDR_FSR) w[15] = 1'b0;
    if (a == fsrc_pkg::ADDR_CAL_ADJ) begin
      w = (w & ~fsrc_pkg::CAL_ADJ_RSVD) | (fsrc_pkg::CAL_ADJ_RESET & fsrc_pkg::CAL_ADJ_RSVD);
    end
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = w;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~w; // Released data must not look valid
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : fsrc_host_model
`default_nettype wire

// ==== fsrc_regs_tb.sv ====
// Self-checking bench for the range and calibration register bank.
// Assumes the host model owns the register strobes.
`timescale 1ns/1ns
`default_nettype none
module fsrc_regs_tb;
  logic        sys_clk, rst, reg_wr, reg_rd, ext, plow, cal_start, busy, t_rst, t_cal, lin, t_done;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cal_res, v;
  logic [14:0] mag;
  int          bad_count = 0;
  int          checks_done = 0;
  int          seed = 32'hB311;
  fsrc_regs i_fsrc_regs (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .extended_control_mode(ext), .pin_range_low(plow), .cal_start(cal_start),
    .cal_result(cal_res), .range_magnitude(mag), .cal_busy(busy), .term_reset(t_rst),
    .term_cal(t_cal), .lin_cal(lin), .term_calibrated(t_done));
  fsrc_host_model i_fsrc_host_model (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_fsrc_host_model.rd(a, d);
    chk(d, exp);
  endtask : rchk
  // Second start inside the run must be ignored, so busy length is fixed
  task automatic run_cal(input logic full);
    int nr = 0;
    int nt = 0;
    int nl = 0;
    int nb = 0;
    int first = -1;
    @(negedge sys_clk);
    cal_start = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      cal_start = (i == 1);
      if (lin === 1'b1 && first < 0) first = nr + nt;
      nr += int'(t_rst === 1'b1);
      nt += int'(t_cal === 1'b1);
      nl += int'(lin === 1'b1);
      nb += int'(busy === 1'b1);
    end
    chk(16'(nr), full ? 16'h0004 : 16'h0000);
    chk(16'(nt), full ? 16'h0004 : 16'h0000);
    chk(16'(nl), 16'h0004);
    chk(16'(first), full ? 16'h0008 : 16'h0000);
    chk(16'(nb), full ? 16'h000D : 16'h0005);
  endtask : run_cal
  initial begin
    rst = 1'b1;
    ext = 1'b1;
    plow = 1'b0;
    cal_start = 1'b0;
    cal_res = 16'($random(seed));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk({1'b0, mag}, fsrc_pkg::FSR_RESET);
    chk({15'h0000, t_done}, 16'h0000);
    rchk(fsrc_pkg::ADDR_FSR, fsrc_pkg::FSR_RESET);
    rchk(fsrc_pkg::ADDR_CAL_ADJ, fsrc_pkg::CAL_ADJ_RESET);
    rchk(fsrc_pkg::ADDR_CAL_VAL, 16'h0000);
    rchk(4'hF, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FFF : 16'($random(seed)) & 16'h7FFF;
      i_fsrc_host_model.wr(fsrc_pkg::ADDR_FSR, v);
      chk({1'b0, mag}, v);
      rchk(fsrc_pkg::ADDR_FSR, v);
    end
    ext = 1'b0;
    for (int i = 0; i < 2; i++) begin
      plow = i[0];
      #1;
      chk({1'b0, mag}, i ? 16'h0000 : 16'h4000);
    end
    ext = 1'b1;
    plow = 1'b0;
    run_cal(1'b1);
    chk({15'h0000, t_done}, 16'h0001);
    rchk(fsrc_pkg::ADDR_CAL_VAL, 16'h0000);
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_CAL_VAL, ~cal_res);
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_CAL_ADJ, 16'hDBCB);
    rchk(fsrc_pkg::ADDR_CAL_VAL, cal_res);
    v = 16'($random(seed));
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_CAL_VAL, v);
    rchk(fsrc_pkg::ADDR_CAL_VAL, v);
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_CAL_ADJ, 16'h9B4B);
    cal_res = 16'($random(seed));
    run_cal(1'b0);
    chk({15'h0000, t_done}, 16'h0001);
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_CAL_ADJ, 16'h9BCB);
    rchk(fsrc_pkg::ADDR_CAL_VAL, cal_res);
    i_fsrc_host_model.wr(fsrc_pkg::ADDR_FSR, 16'h7FFF);
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk({1'b0, mag}, fsrc_pkg::FSR_RESET);
    chk({15'h0000, t_done}, 16'h0000);
    rchk(fsrc_pkg::ADDR_CAL_ADJ, fsrc_pkg::CAL_ADJ_RESET);
    test_done;
  end
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule : fsrc_regs_tb
`default_nettype wire
